// [rtl/icc_channel.sv]
// Interval chronometer channel: input conditioning, state machine and counters.
//
// Contract
// - Gate invert flag inverts gate input.
// - Inverted gating stops counting while gate low.
// - Arm request moves ready state to armed.
// - Armed waits for start, does not count.
// - Rearm flag returns finished to ready immediately.
// - Arm plus rearm repeat measurements automatically.
// - Three status bits mirror armed, counting, finished.
// - Count 25ns reference divided by prescale plus one.
// - 32-bit elapsed counter counts reference pulses.
// - Elapsed counter increments only while counting.
// - Stop copies elapsed count into captured interval.
// - Captured interval is 32-bit last result.
// - Decode condition codes 00, 01, 10.
// - Disabled clears counters; enable goes to ready.
// - Gate use with gate high blocks counting.
// - Armed clears counter; start edge enters counting.
`timescale 1ns/1ns
`default_nettype none

module icc_channel (
    // Clock and synchronous reset.
    input wire logic CLK,
    input wire logic RST,
    // Control flags from host software.
    input wire icc_pkg::icc_ctrl_s CTRL,
    // External measurement pins.
    input wire logic START_STOP_INPUT,
    input wire logic STOP_INPUT,
    input wire logic GATE_INPUT,
    // Status flags for host software.
    output icc_pkg::icc_status_s STATUS,
    // Counter values for host software.
    output logic [31:0] ELAPSED_COUNT,
    output logic [31:0] CAPTURED_INTERVAL
);
    import icc_pkg::*;

    // Raw pins gathered into one vector.
    logic [ICC_NPIN-1:0] pins_raw;
    // First synchroniser stage.
    logic [ICC_NPIN-1:0] sync1_q;
    // Second synchroniser stage, safe to read.
    logic [ICC_NPIN-1:0] sync2_q;
    // Pins after polarity selection.
    logic [ICC_NPIN-1:0] pol_lvl;
    // Polarised levels from the previous cycle.
    logic [ICC_NPIN-1:0] prev_q;
    // Rising edges of the polarised levels.
    logic [ICC_NPIN-1:0] rise;
    // Falling edges of the polarised levels.
    logic [ICC_NPIN-1:0] fall;
    // Per-pin inversion selects.
    logic [ICC_NPIN-1:0] inv_sel;
    // Reference phase accumulator and its next value.
    logic [ICC_PHASE_W-1:0] phase_q;
    logic [ICC_PHASE_W-1:0] phase_sum;
    // One-cycle pulse every 25 ns on average.
    logic ref_tick;
    // Prescaler counter.
    logic [ICC_PRESCALE_W-1:0] presc_q;
    // One-cycle pulse after prescaling.
    logic presc_tick;
    // Counting is blocked by the gate.
    logic gate_block;
    // Start and stop events.
    logic start_evt;
    logic stop_evt;
    // State register and next state.
    icc_state_e state_q;
    icc_state_e state_d;
    // Elapsed counter and captured result.
    logic [ICC_COUNT_W-1:0] elapsed_q;
    logic [ICC_COUNT_W-1:0] captured_q;
    // Registered status flags.
    icc_status_s status_q;

    assign pins_raw[ICC_PIN_SS] = START_STOP_INPUT;
    assign pins_raw[ICC_PIN_STOP] = STOP_INPUT;
    assign pins_raw[ICC_PIN_GATE] = GATE_INPUT;

    // Each pin gets its own inversion flag.
    assign inv_sel[ICC_PIN_SS] = CTRL.start_stop_polarity;
    assign inv_sel[ICC_PIN_STOP] = CTRL.stop_polarity;
    assign inv_sel[ICC_PIN_GATE] = CTRL.gate_invert_ctl;

    // Per-pin synchroniser, polarity and edge detection.
    for (genvar i = 0; i < ICC_NPIN; i++) begin : g_pin
        // Two flip-flops keep metastability away from the logic.
        always_ff @(posedge CLK) begin
            if (RST) begin
                sync1_q[i] <= 1'b0;
                sync2_q[i] <= 1'b0;
            end else begin
                sync1_q[i] <= pins_raw[i];
                sync2_q[i] <= sync1_q[i];
            end
        end

        // Polarity applied only after the second stage.
        assign pol_lvl[i] = sync2_q[i] ^ inv_sel[i];

        // Remembers the previous polarised level.
        always_ff @(posedge CLK) begin
            if (RST) begin
                prev_q[i] <= 1'b0;
            end else begin
                prev_q[i] <= pol_lvl[i];
            end
        end

        // Edges compare this cycle with the last one.
        assign rise[i] = pol_lvl[i] & ~prev_q[i];
        assign fall[i] = ~pol_lvl[i] & prev_q[i];
    end

    // With inversion a low raw gate reads high and blocks counting.
    assign gate_block = CTRL.gate_use_flag & pol_lvl[ICC_PIN_GATE];

    // Start is a rising start/stop edge in every valid condition.
    always_comb begin
        start_evt = 1'b0;
        stop_evt = 1'b0;
        unique case (CTRL.measure_condition_select)
            ICC_COND_HIGH: begin
                // Measures the high time of the start/stop input.
                start_evt = rise[ICC_PIN_SS];
                stop_evt = fall[ICC_PIN_SS];
            end
            ICC_COND_SS_EDGES: begin
                // Period between two rising start/stop edges.
                start_evt = rise[ICC_PIN_SS];
                stop_evt = rise[ICC_PIN_SS];
            end
            ICC_COND_SEP_STOP: begin
                // Start on start/stop, stop on the stop pin.
                start_evt = rise[ICC_PIN_SS];
                stop_evt = rise[ICC_PIN_STOP];
            end
            ICC_COND_UNUSED: begin
                // Unused code never starts or stops a measurement.
                start_evt = 1'b0;
                stop_evt = 1'b0;
            end
        endcase
    end

    // Phase accumulator adds 10 ns per clock and wraps at 25 ns.
    assign phase_sum = phase_q + ICC_PHASE_STEP;
    assign ref_tick = (phase_sum >= ICC_PHASE_WRAP);

    // Reference pulse generator, free running.
    always_ff @(posedge CLK) begin
        if (RST) begin
            phase_q <= '0;
        end else if (ref_tick) begin
            phase_q <= phase_sum - ICC_PHASE_WRAP;
        end else begin
            phase_q <= phase_sum;
        end
    end

    // Prescaler passes one reference pulse in prescale plus one.
    assign presc_tick = ref_tick && (presc_q == CTRL.refclk_prescale);

    // Prescaler restarts at each measurement so phases are repeatable.
    always_ff @(posedge CLK) begin
        if (RST) begin
            presc_q <= ICC_PRESCALE_ZERO;
        end else if (state_q != ICC_COUNTING) begin
            presc_q <= ICC_PRESCALE_ZERO;
        end else if (presc_tick) begin
            presc_q <= ICC_PRESCALE_ZERO;
        end else if (ref_tick && !gate_block) begin
            presc_q <= presc_q + 1'b1;
        end
    end

    // Next state decision.
    always_comb begin
        state_d = state_q;
        if (!CTRL.channel_on_flag) begin
            // Disable acts as a functional reset from any state.
            state_d = ICC_DISABLED;
        end else begin
            unique case (state_q)
                ICC_DISABLED: begin
                    // Enable leads to the ready-to-arm state.
                    state_d = ICC_AWAITING_ARM;
                end
                ICC_AWAITING_ARM: begin
                    // Stays until software sets the arm request.
                    if (CTRL.arm_request) begin
                        state_d = ICC_ARMED;
                    end
                end
                ICC_ARMED: begin
                    // Waits for the start event only.
                    if (start_evt) begin
                        state_d = ICC_COUNTING;
                    end
                end
                ICC_COUNTING: begin
                    // Ends on the stop event.
                    if (stop_evt) begin
                        state_d = ICC_FINISHED;
                    end
                end
                ICC_FINISHED: begin
                    // Rearm returns to ready without delay.
                    if (CTRL.rearm_on_finish) begin
                        state_d = ICC_AWAITING_ARM;
                    end
                end
                default: begin
                    // Recovers from an illegal code.
                    state_d = ICC_DISABLED;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= ICC_DISABLED;
        end else begin
            state_q <= state_d;
        end
    end

    // Status flags follow the next state so they match state_q.
    always_ff @(posedge CLK) begin
        if (RST) begin
            status_q <= '0;
        end else begin
            status_q.waiting_for_start_status <= (state_d == ICC_ARMED);
            status_q.counting_status <= (state_d == ICC_COUNTING);
            status_q.done_status <= (state_d == ICC_FINISHED);
        end
    end

    // Elapsed counter: cleared when disabled or armed, counts while counting, held elsewhere.
    always_ff @(posedge CLK) begin
        if (RST) begin
            elapsed_q <= ICC_COUNT_ZERO;
        end else if (!CTRL.channel_on_flag || state_q == ICC_DISABLED
                     || state_q == ICC_ARMED) begin
            elapsed_q <= ICC_COUNT_ZERO;
        end else if (state_q == ICC_COUNTING && !stop_evt && presc_tick
                     && !gate_block) begin
            elapsed_q <= elapsed_q + 1'b1;
        end
    end

    // Captured interval: cleared when disabled, loaded on stop.
    always_ff @(posedge CLK) begin
        if (RST) begin
            captured_q <= ICC_COUNT_ZERO;
        end else if (!CTRL.channel_on_flag || state_q == ICC_DISABLED) begin
            // Clearing on the low enable flag itself keeps the result zero from the first disabled cycle.
            captured_q <= ICC_COUNT_ZERO;
        end else if (state_q == ICC_COUNTING && stop_evt) begin
            captured_q <= elapsed_q;
        end
    end

    // Outputs come straight from flip-flops.
    assign STATUS = status_q;
    assign ELAPSED_COUNT = elapsed_q;
    assign CAPTURED_INTERVAL = captured_q;

endmodule

`default_nettype wire

// [include/icc_pkg.sv]
// Package with the shared types and constants of the interval chronometer channel.
package icc_pkg;

    // System clock period in nanoseconds.
    localparam int unsigned ICC_CLK_PERIOD_NS = 10;
    // Reference pulse period in nanoseconds.
    localparam int unsigned ICC_REF_PERIOD_NS = 25;
    // Width of the phase accumulator that spaces the reference pulses.
    localparam int unsigned ICC_PHASE_W = 6;
    // Phase step per system clock, in nanoseconds.
    localparam logic [ICC_PHASE_W-1:0] ICC_PHASE_STEP = ICC_PHASE_W'(ICC_CLK_PERIOD_NS);
    // Phase wrap point, one reference period.
    localparam logic [ICC_PHASE_W-1:0] ICC_PHASE_WRAP = ICC_PHASE_W'(ICC_REF_PERIOD_NS);

    // Width of the prescale field.
    localparam int unsigned ICC_PRESCALE_W = 30;
    // Width of the elapsed and captured counters.
    localparam int unsigned ICC_COUNT_W = 32;
    // Number of external pins and their positions.
    localparam int unsigned ICC_NPIN = 3;
    localparam int unsigned ICC_PIN_SS = 0;
    localparam int unsigned ICC_PIN_STOP = 1;
    localparam int unsigned ICC_PIN_GATE = 2;

    // Measurement condition codes.
    localparam logic [1:0] ICC_COND_HIGH = 2'h0;
    localparam logic [1:0] ICC_COND_SS_EDGES = 2'h1;
    localparam logic [1:0] ICC_COND_SEP_STOP = 2'h2;
    localparam logic [1:0] ICC_COND_UNUSED = 2'h3;

    // Zero values for counters.
    localparam logic [ICC_COUNT_W-1:0] ICC_COUNT_ZERO = 32'h0;
    localparam logic [ICC_PRESCALE_W-1:0] ICC_PRESCALE_ZERO = 30'h0;

    // Channel states.
    typedef enum logic [2:0] {
        ICC_DISABLED = 3'b000,
        ICC_AWAITING_ARM = 3'b001,
        ICC_ARMED = 3'b010,
        ICC_COUNTING = 3'b011,
        ICC_FINISHED = 3'b100
    } icc_state_e;

    // Control flags written by host software.
    typedef struct packed {
        logic channel_on_flag;
        logic [1:0] measure_condition_select;
        logic gate_use_flag;
        logic start_stop_polarity;
        logic stop_polarity;
        logic gate_invert_ctl;
        logic arm_request;
        logic rearm_on_finish;
        logic [ICC_PRESCALE_W-1:0] refclk_prescale;
    } icc_ctrl_s;

    // Status flags read by host software.
    typedef struct packed {
        logic waiting_for_start_status;
        logic counting_status;
        logic done_status;
    } icc_status_s;

endpackage

// [verif/icc_channel_properties.sv]
// Concurrent checks on the ports of the interval chronometer channel.
`timescale 1ns/1ns
`default_nettype none
module icc_channel_properties (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST,
    // Watched control and pins.
    input wire icc_pkg::icc_ctrl_s CTRL,
    input wire logic START_STOP_INPUT,
    input wire logic STOP_INPUT,
    input wire logic GATE_INPUT,
    // Watched results.
    input wire icc_pkg::icc_status_s STATUS,
    input wire logic [31:0] ELAPSED_COUNT,
    input wire logic [31:0] CAPTURED_INTERVAL
);
    import icc_pkg::*;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    chk_status_onehot: assert property ($onehot0(STATUS))
        else $error("status bits overlap");
    chk_rearm_now: assert property (STATUS.done_status && CTRL.rearm_on_finish |=> STATUS == 3'h0)
        else $error("no immediate rearm");
    chk_auto_arm: assert property ($fell(STATUS.done_status) && $past(CTRL.rearm_on_finish)
        && $past(CTRL.channel_on_flag) && CTRL.channel_on_flag && CTRL.arm_request
        |=> STATUS.waiting_for_start_status) else $error("no automatic arm");
    chk_armed_clear: assert property (STATUS.waiting_for_start_status &&
        $past(STATUS.waiting_for_start_status) |-> ELAPSED_COUNT == 32'h0)
        else $error("count not clear while armed");
    chk_hold_idle: assert property (!$stable(ELAPSED_COUNT) |->
        $past(STATUS.counting_status) || ELAPSED_COUNT == 32'h0) else $error("count moved idle");
    chk_tick_gap: assert property (!$stable(ELAPSED_COUNT) && CTRL.refclk_prescale == 30'h0
        |=> $stable(ELAPSED_COUNT) || ELAPSED_COUNT == 32'h0) else $error("ticks too close");
    chk_capture_copy: assert property ($rose(STATUS.done_status) |->
        CAPTURED_INTERVAL == ELAPSED_COUNT) else $error("capture differs");
    chk_capture_hold: assert property (!$stable(CAPTURED_INTERVAL) |->
        $rose(STATUS.done_status) || CAPTURED_INTERVAL == 32'h0) else $error("capture moved");
    chk_disabled_zero: assert property (!CTRL.channel_on_flag |=> STATUS == 3'h0 &&
        ELAPSED_COUNT == 32'h0 && CAPTURED_INTERVAL == 32'h0) else $error("disable not clean");
    chk_gate_block: assert property ((CTRL.gate_use_flag && (GATE_INPUT ^ CTRL.gate_invert_ctl))
        [*4] |=> $stable(ELAPSED_COUNT) || ELAPSED_COUNT == 32'h0) else $error("gate ignored");
endmodule
bind icc_channel icc_channel_properties chk_u (.CLK(CLK), .RST(RST), .CTRL(CTRL),
    .START_STOP_INPUT(START_STOP_INPUT), .STOP_INPUT(STOP_INPUT), .GATE_INPUT(GATE_INPUT),
    .STATUS(STATUS), .ELAPSED_COUNT(ELAPSED_COUNT), .CAPTURED_INTERVAL(CAPTURED_INTERVAL));
`default_nettype wire

// [verif/icc_pin_source.sv]
// Model of the external pins that feed the channel's start and stop inputs.
`timescale 1ns/1ns
`default_nettype none
module icc_pin_source (
    // Clock and one-cycle trigger.
    input wire logic clk,
    input wire logic go,
    // Pattern kind and length in clock cycles.
    input wire logic [1:0] mode,
    input wire logic [7:0] dur,
    // Pin levels, idle low.
    output logic ss,
    output logic stp
);
    // Pattern step, negative while idle.
    int step = -1;
    // Pins move on the falling edge, away from the channel's sampling edge.
    always @(negedge clk) begin
        if (go) begin
            step <= 0;
        end else if (step >= 0 && step < int'(dur) + 8) begin
            step <= step + 1;
        end else begin
            step <= -1;
        end
    end
    // Code 00 gives one level of dur cycles; the others give two short rises dur cycles apart.
    assign ss = step >= 0 && (mode == 2'h0 ? step < int'(dur) :
        (step < 2 || (mode != 2'h2 && step >= int'(dur) && step < int'(dur) + 2)));
    assign stp = mode == 2'h2 && step >= int'(dur) && step < int'(dur) + 2;
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the interval chronometer channel.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
    $display("mismatch at %0t: value differs", $time); end end
module testbench;
    import icc_pkg::*;
    // Clock, reset and control word.
    logic clk = 1'b0;
    logic rst = 1'b1;
    icc_ctrl_s ctrl = '0;
    // Partner request and pin conditioning.
    logic go = 1'b0;
    logic ss_inv = 1'b0;
    logic gate = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [7:0] dur = 8'h10;
    logic ss;
    logic stp;
    logic done_prev = 1'b0;
    logic ok;
    // Channel outputs.
    icc_status_s status;
    logic [31:0] elapsed;
    logic [31:0] captured;
    int fail_count = 0;
    int samples_checked = 0;
    int seed = 32'hfd43;
    int exp_v;
    // Expected tick counts, oldest first.
    int exp_q[$];

    always #5 clk = ~clk;
    icc_pin_source pin_u (.clk(clk), .go(go), .mode(mode), .dur(dur), .ss(ss), .stp(stp));
    icc_channel dut_u (.CLK(clk), .RST(rst), .CTRL(ctrl), .START_STOP_INPUT(ss ^ ss_inv),
        .STOP_INPUT(stp ^ ss_inv), .GATE_INPUT(gate), .STATUS(status),
        .ELAPSED_COUNT(elapsed), .CAPTURED_INTERVAL(captured));

    // Prints the verdict and ends the run.
    task automatic finish_test;
        if (fail_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Reads the result only as the done flag rises; one tick of phase slack is allowed.
    always @(negedge clk) begin
        done_prev <= status.done_status;
        if (status.done_status === 1'b1 && done_prev === 1'b0) begin
            `CHK(captured, elapsed)
            exp_v = exp_q.size() > 0 ? exp_q.pop_front() : -9;
            ok = captured + 32'(exp_v != 0) >= 32'(exp_v) && captured <= 32'(exp_v + (exp_v != 0));
            `CHK(ok, 1'b1)
        end
    end

    // One configuration set while disabled, then two measurements with no host action between.
    task automatic measure(input logic [1:0] m, input int p, input int g);
        int n;
        ctrl.channel_on_flag = 1'b0;
        mode = m;
        dur = 8'(12 + {$random(seed)} % 50);
        ss_inv = 1'($random(seed));
        gate = 1'(g);
        ctrl.gate_use_flag = g != 0;
        ctrl.gate_invert_ctl = g > 1;
        ctrl.start_stop_polarity = ss_inv;
        ctrl.stop_polarity = ss_inv;
        ctrl.measure_condition_select = m;
        ctrl.refclk_prescale = 30'(p);
        repeat (4) @(negedge clk);
        `CHK({status, elapsed, captured}, 67'h0)
        ctrl.channel_on_flag = 1'b1;
        repeat (2) begin
            n = 0;
            while (status.waiting_for_start_status !== 1'b1 && n < 20) begin
                @(negedge clk);
                n++;
            end
            `CHK(status.waiting_for_start_status, 1'b1)
            if (m != 2'h3) exp_q.push_back((g == 1 || g == 2) ? 0 : int'(dur) * 2 / 5 / (p + 1));
            go <= 1'b1;
            @(negedge clk);
            go <= 1'b0;
            n = 0;
            while (status.done_status !== 1'b1 && n < 400) begin
                @(negedge clk);
                n++;
            end
            if (m == 2'h3) `CHK(status, 3'h4)
            else `CHK(n < 400, 1'b1)
        end
    endtask

    // Reset, a clear status check before arm, then every code with prescales 0, 1, 2 and four gate settings.
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        ctrl.channel_on_flag = 1'b1;
        ctrl.rearm_on_finish = 1'b1;
        repeat (5) @(negedge clk);
        `CHK(status, 3'h0)
        ctrl.arm_request = 1'b1;
        for (int i = 0; i < 48; i++) begin
            measure(2'(i % 4), (i / 4) % 3, i / 12);
        end
        // Lets the monitor take the last note before the queue is checked.
        @(negedge clk);
        `CHK(exp_q.size(), 0)
        finish_test();
    end
endmodule
`default_nettype wire
